//--- src/alu_core.sv
// Purpose: 16-bit alu with multiplier, iterative divider, barrel shifter
// Assumes: issuer holds operands steady only in the start cycle
// Notes: one-cycle ops answer next cycle, divides after 17 cycles
// What this block does
// RL1: sixteen-bit add, subtract, shift, logic operations
// RL2: arithmetic in two's complement form
// RL3: update carry, zero, negative, overflow, half carry
// RL4: subtract carry is inverted borrow, likewise half
// RL5: byte or word width per instruction
// RL6: operands from registers or memory, same destinations
// RL7: seventeen by seventeen multiplier via extension
// RL8: signed, unsigned, mixed sixteen-bit products
// RL9: sixteen-bit times unsigned five-bit literal
// RL10: unsigned byte by byte product
// RL11: signed/unsigned 32/16 and 16/16 divides
// RL12: quotient to register zero, remainder one
// RL13: any divisor register, even-aligned dividend pair
// RL14: one cycle per divisor bit
// RL15: single-bit and one-cycle multi-bit shifts
// RL16: barrel shift up to fifteen positions
// RL17: multi-bit shifts register direct only
// RL18: arithmetic right shift by one or more
// RL19: logical right shift by one or more
// RL20: left shift by one or more
// RL21: arithmetic fills sign, others fill zero
// RL22: zero divisor still completes, results undefined
//
// Chosen here: the register addresses and the strobed register port.
module alu_core (
   input wire logic clk_i,
   input wire logic arst_n_i,
   output logic div_zero_o,
   alu_link_if.alu lnk
);
   import alu_pkg::*;

   typedef enum logic {ST_IDLE, ST_DIV} dstate_t;

   typedef struct packed {
      dstate_t st;
      logic [3:0] cnt;
      logic [15:0] rem;
      logic [15:0] quo;
      logic [15:0] dvs;
      logic neg_q;
      logic neg_r;
      logic busy;
      logic done;
      logic div_zero;
      logic [15:0] res_lo;
      logic [15:0] res_hi;
      flags_t flags;
      flags_t mask;
   } core_t;

   typedef struct packed {
      logic [15:0] res;
      flags_t f;
   } alu_out_t;

   core_t q_reg;
   core_t q_next;
   logic [16:0] mx;
   logic [16:0] my;
   logic signed [33:0] prod;
   logic [31:0] dd;
   logic [31:0] dd_abs;
   logic sd;
   logic sv;
   logic [16:0] shifted;
   logic [15:0] q_step;
   logic [15:0] r_step;
   alu_out_t o;

   // keep only the low byte in byte mode
   function automatic logic [15:0] fit(input logic [15:0] v,
                                       input logic bm);
      return bm ? {8'h00, v[7:0]} : v;
   endfunction : fit

   // RL3: negative and zero
   function automatic flags_t nz(input logic [15:0] r, input logic bm);
      flags_t f;
      f = '0;
      f.n = bm ? r[7] : r[15];
      f.z = (fit(r, bm) == 16'h0000);
      return f;
   endfunction : nz

   // subtract feeds ~b with carry in, so c and half carry come out
   // as inverted borrows with no extra logic
   function automatic alu_out_t add_op(input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic cin,
                                       input logic bm);
      alu_out_t r;
      logic [16:0] s;
      logic [8:0] s8;
      logic [4:0] s4;
      logic am;
      logic bmsb;
      s = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
      s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
      s4 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      r.res = bm ? {8'h00, s8[7:0]} : s[15:0];
      r.f = nz(r.res, bm);
      // RL4: borrow sense
      r.f.c = bm ? s8[8] : s[16];
      r.f.half_carry_flag = s4[4];
      am = bm ? a[7] : a[15];
      bmsb = bm ? b[7] : b[15];
      // RL2: signed overflow
      r.f.ov = (am == bmsb) && (r.f.n != am);
      return r;
   endfunction : add_op

   // RL7: sign or zero extension
   function automatic logic [16:0] ext17(input logic [15:0] v,
                                         input logic sgn);
      return {sgn & v[15], v};
   endfunction : ext17

   // shared by single and multi-bit shifts
   function automatic logic [15:0] shf(input logic [15:0] a,
                                       input logic [3:0] amt,
                                       input logic right,
                                       input logic arith);
      // RL21: fill rules
      if (!right) begin
         return a << amt;
      end else if (arith) begin
         return $unsigned($signed(a) >>> amt);
      end else begin
         return a >> amt;
      end
   endfunction : shf

   // one restoring divide step on current remainder and quotient
   always_comb begin
      shifted = {q_reg.rem, q_reg.quo[15]};
      if (shifted >= {1'b0, q_reg.dvs}) begin
         r_step = 16'(shifted - {1'b0, q_reg.dvs});
         q_step = {q_reg.quo[14:0], 1'b1};
      end else begin
         r_step = shifted[15:0];
         q_step = {q_reg.quo[14:0], 1'b0};
      end
   end

   // RL11: divide operand prep
   always_comb begin
      unique case (lnk.op)
         OP_DIV_S32, OP_DIV_U32: dd = {lnk.opc, lnk.opa};
         OP_DIV_S16: dd = {{16{lnk.opa[15]}}, lnk.opa};
         default: dd = {16'h0000, lnk.opa};
      endcase
      sd = (lnk.op inside {OP_DIV_S32, OP_DIV_S16}) & dd[31];
      sv = (lnk.op inside {OP_DIV_S32, OP_DIV_S16}) & lnk.opb[15];
      dd_abs = sd ? ~dd + 32'h0000_0001 : dd;
   end

   // multiplier operand select
   always_comb begin
      mx = ext17(lnk.opa, 1'b0);
      my = ext17(lnk.opb, 1'b0);
      unique case (lnk.op)
         // RL8: sixteen-bit modes
         OP_MUL_SS: begin
            mx = ext17(lnk.opa, 1'b1);
            my = ext17(lnk.opb, 1'b1);
         end
         OP_MUL_US: my = ext17(lnk.opb, 1'b1);
         OP_MUL_SU: mx = ext17(lnk.opa, 1'b1);
         // RL9: literal modes
         OP_MUL_LIT_S: begin
            mx = ext17(lnk.opa, 1'b1);
            my = {12'h000, lnk.lit};
         end
         OP_MUL_LIT_U: my = {12'h000, lnk.lit};
         // RL10: byte product
         OP_MUL_BYTE: begin
            mx = {9'h000, lnk.opa[7:0]};
            my = {9'h000, lnk.opb[7:0]};
         end
         default: ;
      endcase
      prod = $signed(mx) * $signed(my);
   end

   // one-cycle operation results and affected flags
   always_comb begin
      o = '0;
      unique case (lnk.op)
         // RL1: add and subtract
         OP_ADD: o = add_op(lnk.opa, lnk.opb, 1'b0, lnk.byte_mode);
         OP_SUB: o = add_op(lnk.opa, ~lnk.opb, 1'b1, lnk.byte_mode);
         OP_AND, OP_IOR, OP_XOR: begin
            o.res = lnk.op == OP_AND ? lnk.opa & lnk.opb :
                    lnk.op == OP_IOR ? lnk.opa | lnk.opb :
                    lnk.opa ^ lnk.opb;
            // RL5: width select
            o.res = fit(o.res, lnk.byte_mode);
            o.f = nz(o.res, lnk.byte_mode);
         end
         // RL15: single-bit shifts
         OP_SHL1: begin
            o.res = fit(shf(lnk.opa, 4'h1, 1'b0, 1'b0), lnk.byte_mode);
            o.f = nz(o.res, lnk.byte_mode);
            o.f.c = lnk.byte_mode ? lnk.opa[7] : lnk.opa[15];
         end
         OP_SHRA1, OP_SHRL1: begin
            o.res = lnk.byte_mode ?
                    {8'h00, lnk.op == OP_SHRA1 & lnk.opa[7],
                     lnk.opa[7:1]} :
                    shf(lnk.opa, 4'h1, 1'b1, lnk.op == OP_SHRA1);
            o.f = nz(o.res, lnk.byte_mode);
            o.f.c = lnk.opa[0];
         end
         // RL16: one-cycle barrel
         // RL20: left by count
         LEFT_SHIFT_OP: o.res = shf(lnk.opa, lnk.opb[3:0], 1'b0, 1'b0);
         // RL18: arithmetic right
         ARITH_RIGHT_SHIFT_OP:
            o.res = shf(lnk.opa, lnk.opb[3:0], 1'b1, 1'b1);
         // RL19: logical right
         LOGIC_RIGHT_SHIFT_OP:
            o.res = shf(lnk.opa, lnk.opb[3:0], 1'b1, 1'b0);
         default: o.res = prod[15:0];
      endcase
      if (lnk.op inside {LEFT_SHIFT_OP, ARITH_RIGHT_SHIFT_OP,
                         LOGIC_RIGHT_SHIFT_OP}) begin
         o.f = nz(o.res, 1'b0);
      end
   end

   // next state: accept, divide steps, finish
   always_comb begin
      q_next = q_reg;
      q_next.done = 1'b0;
      unique case (q_reg.st)
         ST_IDLE: begin
            if (lnk.start) begin
               if (lnk.op inside {OP_DIV_S32, OP_DIV_U32,
                                  OP_DIV_S16, OP_DIV_U16}) begin
                  // RL13: divisor and pair
                  q_next.st = ST_DIV;
                  q_next.busy = 1'b1;
                  q_next.cnt = 4'h0;
                  q_next.rem = dd_abs[31:16];
                  q_next.quo = dd_abs[15:0];
                  q_next.dvs = sv ? ~lnk.opb + 16'h0001 : lnk.opb;
                  q_next.neg_q = sd ^ sv;
                  q_next.neg_r = sd;
                  q_next.div_zero = (lnk.opb == 16'h0000);
               end else begin
                  q_next.done = 1'b1;
                  q_next.res_lo = o.res;
                  q_next.res_hi = prod[31:16];
                  q_next.flags = o.f;
                  // RL3: flags per class
                  unique case (lnk.op)
                     OP_ADD, OP_SUB: q_next.mask = MASK_ALL;
                     OP_AND, OP_IOR, OP_XOR: q_next.mask = MASK_NZ;
                     OP_SHL1, OP_SHRA1, OP_SHRL1: q_next.mask = MASK_CNZ;
                     LEFT_SHIFT_OP, ARITH_RIGHT_SHIFT_OP,
                     LOGIC_RIGHT_SHIFT_OP: q_next.mask = MASK_NZ;
                     default: q_next.mask = MASK_NONE;
                  endcase
                  if (lnk.op == OP_MUL_BYTE) begin
                     q_next.res_hi = WORD_RST;
                  end
               end
            end
         end
         ST_DIV: begin
            // RL14: one bit per cycle
            q_next.rem = r_step;
            q_next.quo = q_step;
            q_next.cnt = q_reg.cnt + 4'h1;
            if (q_reg.cnt == DIV_LAST) begin
               // RL22: no early exit
               // RL12: quotient low, remainder high
               q_next.st = ST_IDLE;
               q_next.busy = 1'b0;
               q_next.done = 1'b1;
               q_next.res_lo = q_reg.neg_q ? ~q_step + 16'h0001 : q_step;
               q_next.res_hi = q_reg.neg_r ? ~r_step + 16'h0001 : r_step;
               q_next.mask = MASK_NONE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign lnk.done = q_reg.done;
   assign lnk.busy = q_reg.busy;
   assign lnk.res_lo = q_reg.res_lo;
   assign lnk.res_hi = q_reg.res_hi;
   assign lnk.flags = q_reg.flags;
   assign lnk.flag_mask = q_reg.mask;
   assign div_zero_o = q_reg.div_zero;
endmodule : alu_core

//--- src/alu_pkg.sv
// Purpose: shared constants and types for the alu core and its issuer
// Assumes: one 40 MHz clock, asynchronous active-low reset
// Notes: flag bit order is c, z, n, ov, half carry from bit 0 upward
package alu_pkg;
   localparam int WORD_W = 16;
   localparam int LIT_W = 5;
   localparam int IDX_W = 4;
   localparam int ADDR_W = 6;
   // divider steps: one per divisor bit
   localparam logic [3:0] DIV_LAST = 4'hf;
   localparam logic [15:0] WORD_RST = 16'h0000;

   // operations; every code past OP_SHRL1 is register direct only
   typedef enum logic [4:0] {
      OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
      OP_SHL1, OP_SHRA1, OP_SHRL1,
      OP_MUL_SS, OP_MUL_UU, OP_MUL_US, OP_MUL_SU,
      OP_MUL_LIT_S, OP_MUL_LIT_U, OP_MUL_BYTE,
      OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16,
      LEFT_SHIFT_OP, ARITH_RIGHT_SHIFT_OP, LOGIC_RIGHT_SHIFT_OP
   } alu_op_t;

   typedef struct packed {
      logic half_carry_flag;
      logic ov;
      logic n;
      logic z;
      logic c;
   } flags_t;

   localparam logic [4:0] MASK_NONE = 5'h00;
   localparam logic [4:0] MASK_NZ = 5'h06;
   localparam logic [4:0] MASK_CNZ = 5'h07;
   localparam logic [4:0] MASK_ALL = 5'h1f;

   // issuer register map
   localparam logic [5:0] DMEM_BASE = 6'h10;
   localparam logic [5:0] CMD_OFS = 6'h20;
   localparam logic [5:0] ISSUE_OFS = 6'h21;
   localparam logic [5:0] STATUS_OFS = 6'h22;
   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BYTE_BIT = 5;
   localparam int CMD_SRC_MEM_BIT = 6;
   localparam int CMD_DST_MEM_BIT = 7;
   localparam int CMD_RA_LSB = 8;
   // issue word fields and the status busy bit
   localparam int ISS_RB_LSB = 0;
   localparam int ISS_RD_LSB = 4;
   localparam int ISS_LIT_LSB = 8;
   localparam int STATUS_BUSY_BIT = 15;
endpackage : alu_pkg

//--- src/alu_link_if.sv
// Purpose: link between the issuing decoder and the alu core
// Assumes: both ends on clk_i, reset arst_n_i
// Notes: start is a one-cycle pulse, done answers it once
interface alu_link_if (
   input wire logic clk_i,
   input wire logic arst_n_i
);
   import alu_pkg::*;
   logic start;
   alu_op_t op;
   logic byte_mode;
   logic [15:0] opa;
   logic [15:0] opb;
   logic [15:0] opc;
   logic [4:0] lit;
   logic done;
   logic busy;
   logic [15:0] res_lo;
   logic [15:0] res_hi;
   flags_t flags;
   flags_t flag_mask;

   modport issuer (
      output start, op, byte_mode, opa, opb, opc, lit,
      input done, busy, res_lo, res_hi, flags, flag_mask
   );
   modport alu (
      input start, op, byte_mode, opa, opb, opc, lit,
      output done, busy, res_lo, res_hi, flags, flag_mask
   );
endinterface : alu_link_if

//--- src/alu_issuer.sv
// Purpose: decoder end; holds working registers, data memory, flags
// Assumes: software port reads answer one cycle after the strobe
// Notes: a second issue while busy is dropped silently
module alu_issuer (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [alu_pkg::ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   alu_link_if.issuer lnk
);
   import alu_pkg::*;

   typedef struct packed {
      logic [15:0][15:0] wreg;
      logic [15:0][15:0] dmem;
      logic [15:0] cmd;
      alu_op_t op;
      logic byte_m;
      logic dst_mem;
      logic [3:0] rd;
      logic pend;
      logic start;
      logic [15:0] opa;
      logic [15:0] opb;
      logic [15:0] opc;
      logic [4:0] lit;
      flags_t arith_flag_register;
      logic [15:0] rdata;
   } iss_t;

   iss_t q_reg;
   iss_t q_next;
   alu_op_t nop;
   logic [3:0] ra;
   logic [3:0] rb;
   logic [3:0] pair;
   logic [15:0] old;

   always_comb begin
      q_next = q_reg;
      q_next.start = 1'b0;
      nop = alu_op_t'(q_reg.cmd[CMD_OP_LSB +: 5]);
      ra = q_reg.cmd[CMD_RA_LSB +: IDX_W];
      rb = wdata_i[ISS_RB_LSB +: IDX_W];
      pair = {ra[3:1], 1'b0};
      old = q_reg.dst_mem ? q_reg.dmem[q_reg.rd] : q_reg.wreg[q_reg.rd];
      // software register port, read answered next cycle
      q_next.rdata = WORD_RST;
      if (rd_i) begin
         if (addr_i < DMEM_BASE) begin
            q_next.rdata = q_reg.wreg[addr_i[3:0]];
         end else if (addr_i < CMD_OFS) begin
            q_next.rdata = q_reg.dmem[addr_i[3:0]];
         end else if (addr_i == CMD_OFS) begin
            q_next.rdata = q_reg.cmd;
         end else if (addr_i == STATUS_OFS) begin
            q_next.rdata = {11'h000, q_reg.arith_flag_register};
            q_next.rdata[STATUS_BUSY_BIT] = q_reg.pend;
         end
      end
      if (wr_i) begin
         if (addr_i < DMEM_BASE) begin
            q_next.wreg[addr_i[3:0]] = wdata_i;
         end else if (addr_i < CMD_OFS) begin
            q_next.dmem[addr_i[3:0]] = wdata_i;
         end else if (addr_i == CMD_OFS) begin
            q_next.cmd = wdata_i;
         end else if (addr_i == ISSUE_OFS && !q_reg.pend) begin
            q_next.start = 1'b1;
            q_next.pend = 1'b1;
            q_next.op = nop;
            q_next.byte_m = q_reg.cmd[CMD_BYTE_BIT];
            q_next.rd = wdata_i[ISS_RD_LSB +: IDX_W];
            q_next.lit = wdata_i[ISS_LIT_LSB +: LIT_W];
            q_next.opb = q_reg.wreg[rb];
            q_next.opc = q_reg.wreg[pair | 4'h1];
            // RL6: register or memory source
            // RL17: direct for shifter
            q_next.dst_mem = q_reg.cmd[CMD_DST_MEM_BIT] && nop <= OP_SHRL1;
            q_next.opa = (q_reg.cmd[CMD_SRC_MEM_BIT] && nop <= OP_SHRL1) ?
                         q_reg.dmem[ra] : q_reg.wreg[ra];
            // RL13: aligned dividend pair
            if (nop inside {OP_DIV_S32, OP_DIV_U32}) begin
               q_next.opa = q_reg.wreg[pair];
            end
         end
      end
      // write-back wins over a software write in the same cycle
      if (lnk.done && q_reg.pend) begin
         q_next.pend = 1'b0;
         q_next.arith_flag_register = (q_reg.arith_flag_register &
                                       ~lnk.flag_mask) |
                                      (lnk.flags & lnk.flag_mask);
         if (q_reg.op inside {OP_DIV_S32, OP_DIV_U32,
                              OP_DIV_S16, OP_DIV_U16}) begin
            // RL12: fixed result registers
            q_next.wreg[0] = lnk.res_lo;
            q_next.wreg[1] = lnk.res_hi;
         end else if (q_reg.op inside {OP_MUL_SS, OP_MUL_UU, OP_MUL_US,
                                       OP_MUL_SU, OP_MUL_LIT_S,
                                       OP_MUL_LIT_U}) begin
            q_next.wreg[{q_reg.rd[3:1], 1'b0}] = lnk.res_lo;
            q_next.wreg[{q_reg.rd[3:1], 1'b1}] = lnk.res_hi;
         end else if (q_reg.dst_mem) begin
            // RL5: byte keeps upper half
            q_next.dmem[q_reg.rd] = q_reg.byte_m ?
                                    {old[15:8], lnk.res_lo[7:0]} :
                                    lnk.res_lo;
         end else begin
            q_next.wreg[q_reg.rd] = q_reg.byte_m ?
                                    {old[15:8], lnk.res_lo[7:0]} :
                                    lnk.res_lo;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign rdata_o = q_reg.rdata;
   assign lnk.start = q_reg.start;
   assign lnk.op = q_reg.op;
   assign lnk.byte_mode = q_reg.byte_m;
   assign lnk.opa = q_reg.opa;
   assign lnk.opb = q_reg.opb;
   assign lnk.opc = q_reg.opc;
   assign lnk.lit = q_reg.lit;
endmodule : alu_issuer

//--- tb/alu_link_assertions.sv
// Purpose: timing and result checks on the issuer to alu link
// Assumes: one clock, asynchronous active-low reset
// Notes: results are tied to operands seen in the start cycle
module alu_link_assertions
   import alu_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic start,
   input wire alu_pkg::alu_op_t op,
   input wire logic byte_mode,
   input wire logic [15:0] opa,
   input wire logic [15:0] opb,
   input wire logic [15:0] opc,
   input wire logic [4:0] lit,
   input wire logic done,
   input wire logic busy,
   input wire logic [15:0] res_lo,
   input wire logic [15:0] res_hi,
   input wire alu_pkg::flags_t flags,
   input wire alu_pkg::flags_t flag_mask
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic go;
   logic go_w;
   logic is_div;
   // a start only counts while the core is idle
   assign go = start && !busy;
   assign go_w = go && !byte_mode;
   assign is_div = op inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16};
   // sixteen steps with busy standing, then done
   sequence div_steps;
      busy [*8] ##1 busy [*8];
   endsequence
   sequence div_finish;
      done && !busy;
   endsequence
   a_div_length: assert property (go && is_div |=>
      div_steps ##1 div_finish)
      else $error("divide length wrong");
   a_quick_done: assert property (go && !is_div |=> done)
      else $error("single cycle op late");
   a_no_stray: assert property (done |->
      $past(go && !is_div) || $past(busy))
      else $error("done without a request");
   a_shift_left: assert property (go && op == LEFT_SHIFT_OP |=>
      res_lo == ($past(opa) << $past(opb[3:0])))
      else $error("left shift result wrong");
   a_arith_right: assert property (go &&
      op == ARITH_RIGHT_SHIFT_OP |=>
      res_lo == 16'($signed($past(opa)) >>> $past(opb[3:0])))
      else $error("arithmetic shift result wrong");
   a_logic_right: assert property (go && op == LOGIC_RIGHT_SHIFT_OP |=>
      res_lo == ($past(opa) >> $past(opb[3:0])))
      else $error("logical shift result wrong");
   a_mul_signed: assert property (go_w && op == OP_MUL_SS |=>
      {res_hi, res_lo} == 32'($signed($past(opa))) * 32'($signed($past(opb))))
      else $error("signed product wrong");
   a_mul_unsigned: assert property (go_w && op == OP_MUL_UU |=>
      {res_hi, res_lo} == 32'($past(opa)) * 32'($past(opb)))
      else $error("unsigned product wrong");
   a_add_word: assert property (go_w && op == OP_ADD |=>
      {flags.c, res_lo} == 17'($past(opa)) + 17'($past(opb)))
      else $error("word add wrong");
   // logic ops touch n and z only
   a_logic_mask: assert property (go &&
      op inside {OP_AND, OP_IOR, OP_XOR} |=> flag_mask == MASK_NZ)
      else $error("logic op flag mask wrong");
endmodule : alu_link_assertions

//--- tb/test_cpu_alu_mul_div_shift.sv
// Purpose: drives the issuer port and checks results against a bench model
// Assumes: 40 MHz clock, reset low for three cycles
// Notes: reads queue their expected value; a monitor checks returning data
module test_cpu_alu_mul_div_shift;
   timeunit 1ns;
   timeprecision 1ps;
   import alu_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic [15:0] rdata;
   logic dz;
   logic [15:0] exp_q[$];
   logic [31:0] seed = 32'h4e9d;
   logic [15:0] fa[4] = '{16'hffff, 16'h7fff, 16'h0000, 16'h0005};
   logic [15:0] fb[4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0003};
   logic [15:0] fs[4] = '{16'h0013, 16'h001c, 16'h0004, 16'h0011};
   int failures = 0;
   int checks_done = 0;
   int waited;
   always #12.5 clk_i = ~clk_i;
   alu_link_if link (.clk_i(clk_i), .arst_n_i(arst_n_i));
   alu_core alu_core_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .div_zero_o(dz), .lnk(link));
   alu_issuer alu_issuer_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lnk(link));
   alu_link_assertions chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .start(link.start), .op(link.op), .byte_mode(link.byte_mode),
      .opa(link.opa), .opb(link.opb), .opc(link.opc), .lit(link.lit),
      .done(link.done), .busy(link.busy), .res_lo(link.res_lo),
      .res_hi(link.res_hi), .flags(link.flags), .flag_mask(link.flag_mask));
   // xorshift, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // bench model of the non-divide ops, {hi, lo}
   function automatic logic [31:0] model(input alu_op_t o,
         input logic [15:0] a, input logic [15:0] b, input logic [4:0] l);
      case (o)
         OP_ADD: return {16'h0, a + b};
         OP_SUB: return {16'h0, a - b};
         OP_AND: return {16'h0, a & b};
         OP_IOR: return {16'h0, a | b};
         OP_XOR: return {16'h0, a ^ b};
         OP_SHL1: return {16'h0, a << 1};
         OP_SHRA1: return {16'h0, a[15], a[15:1]};
         OP_SHRL1: return {16'h0, a >> 1};
         OP_MUL_SS: return 32'($signed(a)) * 32'($signed(b));
         OP_MUL_UU: return 32'(a) * 32'(b);
         OP_MUL_US: return 32'(a) * 32'($signed(b));
         OP_MUL_SU: return 32'($signed(a)) * 32'(b);
         OP_MUL_LIT_S: return 32'($signed(a)) * 32'(l);
         OP_MUL_LIT_U: return 32'(a) * 32'(l);
         OP_MUL_BYTE: return 32'(a[7:0]) * 32'(b[7:0]);
         LEFT_SHIFT_OP: return {16'h0, a << b[3:0]};
         ARITH_RIGHT_SHIFT_OP: return {16'h0, 16'($signed(a) >>> b[3:0])};
         default: return {16'h0, a >> b[3:0]};
      endcase
   endfunction : model
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // one bus cycle; strobes change only right after an edge
   task automatic bus(input logic [5:0] a, input logic [15:0] d,
         input logic w, input logic r);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= r;
      @(posedge clk_i);
   endtask : bus
   task automatic rdx(input logic [5:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      bus(a, 16'h0000, 1'b0, 1'b1);
   endtask : rdx
   // command, issue, then a bounded wait for done
   task automatic run(input alu_op_t o, input logic [2:0] m,
         input logic [3:0] ra, input logic [15:0] iss);
      bus(CMD_OFS, {4'h0, ra, m, o}, 1'b1, 1'b0);
      bus(ISSUE_OFS, iss, 1'b1, 1'b0);
      bus(6'h00, 16'h0000, 1'b0, 1'b0);
      waited = 0;
      @(negedge clk_i);
      while (link.done !== 1'b1 && waited < 40) begin
         waited++;
         @(negedge clk_i);
      end
      if (waited >= 40) begin
         failures++;
         end_sim();
      end
      @(posedge clk_i);
   endtask : run
   // read data lands one cycle after the strobe
   always @(posedge clk_i) begin
      rd_q <= rd;
      if (rd_q)
         check(rdata, exp_q.pop_front());
   end
   // hang guard, well above the real run length
   initial begin
      repeat (100000) @(posedge clk_i);
      failures++;
      end_sim();
   end
   initial begin
      alu_op_t o;
      logic [31:0] r;
      logic [31:0] p;
      logic [15:0] a;
      logic [15:0] b;
      logic s;
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      rdx(6'h04, 16'h0000);
      rdx(STATUS_OFS, 16'h0000);
      rdx(ISSUE_OFS, 16'h0000);
      rdx(6'h30, 16'h0000);
      $display("reset and map test done");
      // every non-divide op on random operands
      repeat (2) begin
         for (int i = 0; i < 22; i++) begin
            o = alu_op_t'(i);
            if (o inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16})
               continue;
            r = rnd();
            bus(6'h02, r[15:0], 1'b1, 1'b0);
            bus(6'h03, r[31:16], 1'b1, 1'b0);
            run(o, 3'h0, 4'h2, {3'h0, r[20:16], 8'h43});
            p = model(o, r[15:0], r[31:16], r[20:16]);
            rdx(6'h04, p[15:0]);
            if (i >= 8 && i <= 13)
               rdx(6'h05, p[31:16]);
         end
      end
      $display("op table test done");
      // carry, borrow, overflow and digit flags
      for (int i = 0; i < 4; i++) begin
         bus(6'h02, fa[i], 1'b1, 1'b0);
         bus(6'h03, fb[i], 1'b1, 1'b0);
         run(i < 2 ? OP_ADD : OP_SUB, 3'h0, 4'h2, 16'h0043);
         rdx(STATUS_OFS, fs[i]);
      end
      // byte add from memory to memory keeps upper byte
      bus(6'h12, 16'h12f0, 1'b1, 1'b0);
      bus(6'h15, 16'hab00, 1'b1, 1'b0);
      bus(6'h03, 16'h0025, 1'b1, 1'b0);
      run(OP_ADD, 3'h7, 4'h2, 16'h0053);
      rdx(6'h15, 16'hab15);
      rdx(STATUS_OFS, 16'h0001);
      $display("flag and width test done");
      // all four divides, divisor at least two in magnitude
      for (int i = 15; i < 19; i++) begin
         o = alu_op_t'(i);
         r = rnd();
         a = r[15:0];
         b = {1'b0, r[30:16]} | 16'h0002;
         s = (o == OP_DIV_S32 || o == OP_DIV_S16);
         // signed divides also meet a negative divisor
         if (s && r[31])
            b = -b;
         bus(6'h06, a, 1'b1, 1'b0);
         bus(6'h07, s ? {16{a[15]}} : 16'h0000, 1'b1, 1'b0);
         bus(6'h09, b, 1'b1, 1'b0);
         run(o, 3'h0, 4'h6, 16'h0009);
         check(16'(waited), 16'h0010);
         rdx(6'h00, s ? 16'($signed(a) / $signed(b)) : a / b);
         rdx(6'h01, s ? 16'($signed(a) % $signed(b)) : a % b);
      end
      // zero divisor still takes the normal length
      bus(6'h09, 16'h0000, 1'b1, 1'b0);
      run(OP_DIV_U16, 3'h0, 4'h6, 16'h0009);
      check(16'(waited), 16'h0010);
      check({15'h0, dz}, 16'h0001);
      $display("divide test done");
      bus(6'h00, 16'h0000, 1'b0, 1'b0);
      bus(6'h00, 16'h0000, 1'b0, 1'b0);
      end_sim();
   end
endmodule : test_cpu_alu_mul_div_shift
